// file: rtl/cam_cfg_pkg.sv
// Functional notes
// R1 - sequence count sets back-to-back captures
// R2 - sequence 1 uses second integration time
// R3 - sequence 0 uses general exposure time
// R4 - sequence 1 uses second modulation frequency
// R5 - read-only update status reports one code
// R6 - bits 0,1,3,4 enable distance filters
// R7 - bits 6,7 enable wiggling and noise compensation
// R8 - bits 10,11 enable frame average, temperature
// R9 - bit 13 adds per-frequency range offset; code adds none in the cycle after a host offset read
// R10 - bit 14 sets failing pixels to one
// R11 - median iterations in bits 0 to 7
// R12 - average low byte selects kernel size
// R13 - average iterations in bits 8 to 15
// R14 - bilateral range, spatial, iteration fields
// R15 - square size gives window size squared
// R16 - frame average count in bits 0 to 7
// R17 - amplitude filter enables in bits 0 to 3
// R18 - seven offsets, one per predefined frequency
// R19 - undocumented bits ignored, read as zero
// constants shared by the register bank and its offset store
// assumes 16-bit word registers on a single register clock
package cam_cfg_pkg;
  localparam logic [15:0] addr_sequence_count = 16'h0120;
  localparam logic [15:0] addr_seq1_int_time = 16'h0121;
  localparam logic [15:0] addr_seq1_mod_freq = 16'h0128;
  localparam logic [15:0] addr_update_status = 16'h01d1;
  localparam logic [15:0] addr_dist_enables = 16'h01e0;
  localparam logic [15:0] addr_median_iter = 16'h01e1;
  localparam logic [15:0] addr_average_cfg = 16'h01e2;
  localparam logic [15:0] addr_edge_cfg = 16'h01e4;
  localparam logic [15:0] addr_slide_window = 16'h01e5;
  localparam logic [15:0] addr_edge_square = 16'h01e6;
  localparam logic [15:0] addr_frame_avg = 16'h01e7;
  localparam logic [15:0] addr_amp_enables = 16'h01e9;
  localparam logic [15:0] addr_offset_base = 16'h00c1;
  localparam int offset_count = 7;

  localparam logic [15:0] rst_sequence_count = 16'h0001;
  localparam logic [15:0] rst_seq1_int_time = 16'h05dc;
  localparam logic [15:0] rst_seq1_mod_freq = 16'h07d0;
  localparam logic [15:0] rst_update_status = 16'h0000;
  localparam logic [15:0] rst_dist_enables = 16'h28c0;
  localparam logic [15:0] rst_median_iter = 16'h0001;
  localparam logic [15:0] rst_average_cfg = 16'h0100;
  localparam logic [15:0] rst_edge_cfg = 16'h13de;
  localparam logic [15:0] rst_slide_window = 16'h0005;
  localparam logic [15:0] rst_edge_square = 16'h0003;
  localparam logic [15:0] rst_frame_avg = 16'h0002;
  localparam logic [15:0] rst_amp_enables = 16'h0000;
  localparam logic [15:0] rst_offset = 16'h0000;

  // writable-bit masks
  localparam logic [15:0] mask_dist_enables = 16'h6cdb;
  localparam logic [15:0] mask_byte = 16'h00ff;
  localparam logic [15:0] mask_six = 16'h003f;
  localparam logic [15:0] mask_amp_enables = 16'h000f;
  localparam logic [15:0] mask_full = 16'hffff;

  localparam int bit_dist_median = 0;
  localparam int bit_dist_average = 1;
  localparam int bit_dist_bilateral = 3;
  localparam int bit_dist_sliding = 4;
  localparam int bit_wiggling = 6;
  localparam int bit_phase_noise = 7;
  localparam int bit_frame_average = 10;
  localparam int bit_temperature = 11;
  localparam int bit_range_offset = 13;
  localparam int bit_plausibility = 14;

  localparam logic [7:0] kernel_3x3 = 8'h00;
  localparam logic [7:0] kernel_5x5 = 8'h01;
  localparam logic [7:0] kernel_2x2 = 8'h02;

  localparam logic [15:0] invalid_distance = 16'h0001;

  localparam logic [7:0] st_idle = 8'h00;
  localparam logic [7:0] st_out_of_memory = 8'h03;
  localparam logic [7:0] st_checksum_error = 8'h06;
  localparam logic [7:0] st_erasing = 8'h08;
  localparam logic [7:0] st_programming = 8'h09;
  localparam logic [7:0] st_erase_failed = 8'h0b;
  localparam logic [7:0] st_program_failed = 8'h0c;
  localparam logic [7:0] st_success = 8'h0e;
  localparam logic [7:0] st_header_conflict = 8'h10;
  localparam logic [7:0] st_wrong_identifier = 8'h12;
  localparam logic [7:0] st_inconsistent = 8'h14;
  localparam logic [7:0] st_in_progress = 8'h15;
  localparam logic [7:0] st_protocol_violation = 8'hff;
endpackage

// file: rtl/offset_bus_if.sv
// carrier between register bank and its offset store
// assumes a single ref_clk domain
`timescale 1ns/1ps
interface offset_bus_if;
  logic wr_en;
  logic [2:0] wr_index;
  logic [15:0] wr_data;
  logic [2:0] rd_index;
  logic [15:0] rd_data;
  modport bank (output wr_en, output wr_index, output wr_data, output rd_index, input rd_data);
  modport store (input wr_en, input wr_index, input wr_data, input rd_index, output rd_data);
endinterface

// file: rtl/range_offset_store.sv
// seven range offsets, one per predefined modulation frequency
// read data registered: answers one cycle after rd_index
`timescale 1ns/1ps
module range_offset_store
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  offset_bus_if.store bus
);
  logic [15:0] mem [cam_cfg_pkg::offset_count];
  logic [15:0] next_mem [cam_cfg_pkg::offset_count];
  logic [15:0] rd_data;
  logic [15:0] next_rd_data;

  assign bus.rd_data = rd_data;

  // ==========================================
  // storage
  always_comb
  begin
    next_mem = mem;
    // R18 one per frequency
    if (bus.wr_en && (int'(bus.wr_index) < cam_cfg_pkg::offset_count))
    begin
      next_mem[bus.wr_index] = bus.wr_data;
    end
    next_rd_data = (int'(bus.rd_index) < cam_cfg_pkg::offset_count) ? mem[bus.rd_index] : 16'h0000;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < cam_cfg_pkg::offset_count; i++)
      begin
        mem[i] <= cam_cfg_pkg::rst_offset;
      end
      rd_data <= 16'h0000;
    end
    else
    begin
      mem <= next_mem;
      rd_data <= next_rd_data;
    end
  end
endmodule

// file: rtl/depth_camera_proc_config_regs.sv
// configuration and status register bank for the depth camera
// host access via simple addressed word port on ref_clk; capture and
// pixel pipeline logic outside consume the decoded controls
`timescale 1ns/1ps
module depth_camera_proc_config_regs
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [7:0] update_status_in,
  input wire logic update_status_load,
  input wire logic [15:0] exposure_duration,
  input wire logic [15:0] illumination_mod_frequency,
  input wire logic capture_start,
  output logic capture_active,
  output logic sequence_index,
  output logic [15:0] active_exposure,
  output logic [15:0] active_mod_frequency,
  input wire logic [2:0] active_freq_index,
  input wire logic [15:0] pixel_distance_in,
  input wire logic pixel_valid_in,
  input wire logic pixel_plausible_in,
  output logic [15:0] pixel_distance_out,
  output logic pixel_valid_out,
  output logic en_dist_median,
  output logic en_dist_average,
  output logic en_dist_bilateral,
  output logic en_dist_sliding,
  output logic en_wiggling,
  output logic en_phase_noise,
  output logic en_frame_average,
  output logic en_temperature,
  output logic [7:0] median_iter_count,
  output logic [7:0] average_kernel_sel,
  output logic [7:0] average_iter_count,
  output logic [5:0] edge_range_width,
  output logic [5:0] edge_spatial_width,
  output logic [3:0] edge_iter_count,
  output logic [7:0] slide_window_size,
  output logic [11:0] edge_window_pixels,
  output logic [7:0] frame_avg_count,
  output logic [3:0] amp_filter_enables
);
  typedef enum logic [1:0] {cap_idle = 2'b01, cap_run = 2'b10} cap_state_type;

  logic [15:0] sequence_count, second_sequence_integration_time, second_sequence_mod_frequency;
  logic [15:0] distance_processing_enables, median_iterations, average_kernel_config;
  logic [15:0] edge_preserving_config, sliding_average_window, edge_preserving_square_size;
  logic [15:0] frame_average_count, amplitude_processing_enables, update_status_code;
  logic [15:0] next_sequence_count, next_second_sequence_integration_time, next_second_sequence_mod_frequency;
  logic [15:0] next_distance_processing_enables, next_median_iterations, next_average_kernel_config;
  logic [15:0] next_edge_preserving_config, next_sliding_average_window, next_edge_preserving_square_size;
  logic [15:0] next_frame_average_count, next_amplitude_processing_enables, next_update_status_code;
  logic [15:0] next_reg_rdata, bank_rdata, offset_addr_diff, seq_left, next_seq_left, next_pixel_distance_out;
  logic [15:0] applied_offset;
  logic next_reg_rvalid, offset_hit, offset_hit_q, next_offset_hit_q, next_sequence_index, next_pixel_valid_out;
  cap_state_type cap_state, next_cap_state;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  offset_bus_if obus();

  range_offset_store u_store
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .bus(obus.store)
  );

  assign offset_addr_diff = reg_addr - cam_cfg_pkg::addr_offset_base;
  assign offset_hit = (reg_addr >= cam_cfg_pkg::addr_offset_base) && (offset_addr_diff < 16'(cam_cfg_pkg::offset_count));

  // ==========================================
  // register writes
  always_comb
  begin
    next_sequence_count = sequence_count;
    next_second_sequence_integration_time = second_sequence_integration_time;
    next_second_sequence_mod_frequency = second_sequence_mod_frequency;
    next_distance_processing_enables = distance_processing_enables;
    next_median_iterations = median_iterations;
    next_average_kernel_config = average_kernel_config;
    next_edge_preserving_config = edge_preserving_config;
    next_sliding_average_window = sliding_average_window;
    next_edge_preserving_square_size = edge_preserving_square_size;
    next_frame_average_count = frame_average_count;
    next_amplitude_processing_enables = amplitude_processing_enables;
    next_update_status_code = update_status_code;
    // R5 status from updater only
    if (update_status_load)
      next_update_status_code = {8'h00, update_status_in};
    if (reg_wr)
    begin
      // R19 masks drop undocumented bits
      case (reg_addr)
        cam_cfg_pkg::addr_sequence_count: next_sequence_count = reg_wdata;
        cam_cfg_pkg::addr_seq1_int_time: next_second_sequence_integration_time = reg_wdata;
        cam_cfg_pkg::addr_seq1_mod_freq: next_second_sequence_mod_frequency = reg_wdata;
        cam_cfg_pkg::addr_dist_enables: next_distance_processing_enables = reg_wdata & cam_cfg_pkg::mask_dist_enables;
        cam_cfg_pkg::addr_median_iter: next_median_iterations = reg_wdata & cam_cfg_pkg::mask_byte;
        cam_cfg_pkg::addr_average_cfg: next_average_kernel_config = reg_wdata & cam_cfg_pkg::mask_full;
        cam_cfg_pkg::addr_edge_cfg: next_edge_preserving_config = reg_wdata & cam_cfg_pkg::mask_full;
        cam_cfg_pkg::addr_slide_window: next_sliding_average_window = reg_wdata & cam_cfg_pkg::mask_byte;
        cam_cfg_pkg::addr_edge_square: next_edge_preserving_square_size = reg_wdata & cam_cfg_pkg::mask_six;
        cam_cfg_pkg::addr_frame_avg: next_frame_average_count = reg_wdata & cam_cfg_pkg::mask_byte;
        cam_cfg_pkg::addr_amp_enables: next_amplitude_processing_enables = reg_wdata & cam_cfg_pkg::mask_amp_enables;
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sequence_count <= cam_cfg_pkg::rst_sequence_count;
      second_sequence_integration_time <= cam_cfg_pkg::rst_seq1_int_time;
      second_sequence_mod_frequency <= cam_cfg_pkg::rst_seq1_mod_freq;
      distance_processing_enables <= cam_cfg_pkg::rst_dist_enables;
      median_iterations <= cam_cfg_pkg::rst_median_iter;
      average_kernel_config <= cam_cfg_pkg::rst_average_cfg;
      edge_preserving_config <= cam_cfg_pkg::rst_edge_cfg;
      sliding_average_window <= cam_cfg_pkg::rst_slide_window;
      edge_preserving_square_size <= cam_cfg_pkg::rst_edge_square;
      frame_average_count <= cam_cfg_pkg::rst_frame_avg;
      amplitude_processing_enables <= cam_cfg_pkg::rst_amp_enables;
      update_status_code <= cam_cfg_pkg::rst_update_status;
    end
    else
    begin
      sequence_count <= next_sequence_count;
      second_sequence_integration_time <= next_second_sequence_integration_time;
      second_sequence_mod_frequency <= next_second_sequence_mod_frequency;
      distance_processing_enables <= next_distance_processing_enables;
      median_iterations <= next_median_iterations;
      average_kernel_config <= next_average_kernel_config;
      edge_preserving_config <= next_edge_preserving_config;
      sliding_average_window <= next_sliding_average_window;
      edge_preserving_square_size <= next_edge_preserving_square_size;
      frame_average_count <= next_frame_average_count;
      amplitude_processing_enables <= next_amplitude_processing_enables;
      update_status_code <= next_update_status_code;
    end
  end

  // R18 offset store port
  assign obus.wr_en = reg_wr && offset_hit;
  assign obus.wr_index = offset_addr_diff[2:0];
  assign obus.wr_data = reg_wdata;
  assign obus.rd_index = (reg_rd && offset_hit) ? offset_addr_diff[2:0] : active_freq_index;

  // ==========================================
  // register reads, one cycle latency
  always_comb
  begin
    next_reg_rdata = 16'h0000;
    next_reg_rvalid = reg_rd;
    next_offset_hit_q = reg_rd && offset_hit;
    if (reg_rd)
    begin
      case (reg_addr)
        cam_cfg_pkg::addr_sequence_count: next_reg_rdata = sequence_count;
        cam_cfg_pkg::addr_seq1_int_time: next_reg_rdata = second_sequence_integration_time;
        cam_cfg_pkg::addr_seq1_mod_freq: next_reg_rdata = second_sequence_mod_frequency;
        cam_cfg_pkg::addr_update_status: next_reg_rdata = update_status_code;
        cam_cfg_pkg::addr_dist_enables: next_reg_rdata = distance_processing_enables;
        cam_cfg_pkg::addr_median_iter: next_reg_rdata = median_iterations;
        cam_cfg_pkg::addr_average_cfg: next_reg_rdata = average_kernel_config;
        cam_cfg_pkg::addr_edge_cfg: next_reg_rdata = edge_preserving_config;
        cam_cfg_pkg::addr_slide_window: next_reg_rdata = sliding_average_window;
        cam_cfg_pkg::addr_edge_square: next_reg_rdata = edge_preserving_square_size;
        cam_cfg_pkg::addr_frame_avg: next_reg_rdata = frame_average_count;
        cam_cfg_pkg::addr_amp_enables: next_reg_rdata = amplitude_processing_enables;
        default: next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bank_rdata <= 16'h0000;
      reg_rvalid <= 1'b0;
      offset_hit_q <= 1'b0;
    end
    else
    begin
      bank_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      offset_hit_q <= next_offset_hit_q;
    end
  end
  assign reg_rdata = offset_hit_q ? obus.rd_data : bank_rdata;

  // ==========================================
  // capture sequencing
  always_comb
  begin
    next_cap_state = cap_state;
    next_seq_left = seq_left;
    next_sequence_index = sequence_index;
    case (cap_state)
      cap_idle:
        if (capture_start && (sequence_count != 16'h0000))
        begin
          next_cap_state = cap_run;
          next_seq_left = sequence_count - 16'h0001;
          next_sequence_index = 1'b0;
        end
      // R1 no wait between sequences
      cap_run:
        if (seq_left != 16'h0000)
        begin
          next_seq_left = seq_left - 16'h0001;
          next_sequence_index = 1'b1;
        end
        else
        begin
          next_cap_state = cap_idle;
          next_sequence_index = 1'b0;
        end
      default: next_cap_state = cap_idle;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cap_state <= cap_idle;
      seq_left <= 16'h0000;
      sequence_index <= 1'b0;
    end
    else
    begin
      cap_state <= next_cap_state;
      seq_left <= next_seq_left;
      sequence_index <= next_sequence_index;
    end
  end

  assign capture_active = (cap_state == cap_run);
  // R2 second integration time
  // R3 sequence 0 general time
  assign active_exposure = sequence_index ? second_sequence_integration_time : exposure_duration;
  // R4 second modulation frequency
  assign active_mod_frequency = sequence_index ? second_sequence_mod_frequency : illumination_mod_frequency;

  // ==========================================
  // pixel correction stage
  // host offset reads borrow the store port for one cycle; pixel data then skip the offset
  assign applied_offset = offset_hit_q ? 16'h0000 : obus.rd_data;
  always_comb
  begin
    next_pixel_valid_out = pixel_valid_in;
    next_pixel_distance_out = pixel_distance_in;
    // R9 add range offset
    if (distance_processing_enables[cam_cfg_pkg::bit_range_offset])
      next_pixel_distance_out = 16'(pixel_distance_in + applied_offset);
    // R10 failed pixels set to one
    if (distance_processing_enables[cam_cfg_pkg::bit_plausibility] && !pixel_plausible_in)
      next_pixel_distance_out = cam_cfg_pkg::invalid_distance;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pixel_distance_out <= 16'h0000;
      pixel_valid_out <= 1'b0;
    end
    else
    begin
      pixel_distance_out <= next_pixel_distance_out;
      pixel_valid_out <= next_pixel_valid_out;
    end
  end

  // ==========================================
  // decoded controls
  // R6 distance filter enables
  assign en_dist_median = distance_processing_enables[cam_cfg_pkg::bit_dist_median];
  assign en_dist_average = distance_processing_enables[cam_cfg_pkg::bit_dist_average];
  assign en_dist_bilateral = distance_processing_enables[cam_cfg_pkg::bit_dist_bilateral];
  assign en_dist_sliding = distance_processing_enables[cam_cfg_pkg::bit_dist_sliding];
  // R7 compensation enables
  assign en_wiggling = distance_processing_enables[cam_cfg_pkg::bit_wiggling];
  assign en_phase_noise = distance_processing_enables[cam_cfg_pkg::bit_phase_noise];
  // R8 frame and temperature
  assign en_frame_average = distance_processing_enables[cam_cfg_pkg::bit_frame_average];
  assign en_temperature = distance_processing_enables[cam_cfg_pkg::bit_temperature];
  // R11 median iteration field
  assign median_iter_count = median_iterations[7:0];
  // R12 kernel select byte
  assign average_kernel_sel = average_kernel_config[7:0];
  // R13 average iteration field
  assign average_iter_count = average_kernel_config[15:8];
  // R14 bilateral fields
  assign edge_range_width = edge_preserving_config[5:0];
  assign edge_spatial_width = edge_preserving_config[11:6];
  assign edge_iter_count = edge_preserving_config[15:12];
  assign slide_window_size = sliding_average_window[7:0];
  // R15 window is square squared
  assign edge_window_pixels = 12'(edge_preserving_square_size[5:0] * edge_preserving_square_size[5:0]);
  // R16 frame count field
  assign frame_avg_count = frame_average_count[7:0];
  // R17 amplitude filter enables
  assign amp_filter_enables = amplitude_processing_enables[3:0];

  // ==========================================
  // checks
  seq_one_uses_second_a: assert property (sequence_index |-> // R2
    active_exposure == second_sequence_integration_time) else $error("sequence 1 exposure mismatch");
  seq_zero_general_a: assert property (!sequence_index |-> // R3
    active_exposure == exposure_duration) else $error("sequence 0 exposure mismatch");
  seq_count_length_a: assert property (cap_state == cap_idle && capture_start && sequence_count == 16'h0002 |=> // R1
    capture_active [*2] ##1 !capture_active) else $error("capture length wrong");
  status_readonly_a: assert property (!update_status_load |=> // R5
    $stable(update_status_code)) else $error("status changed without load");
  plaus_forces_one_a: assert property (distance_processing_enables[14] && !pixel_plausible_in |=> // R10
    pixel_distance_out == 16'h0001) else $error("implausible pixel not set to one");
  undoc_bits_zero_a: assert property ((distance_processing_enables & 16'h9324) == 16'h0000 && // R19
    amplitude_processing_enables[15:4] == 12'h000) else $error("undocumented bits set");
  square_window_a: assert property (reg_wr && reg_addr == 16'h01e6 && reg_wdata == 16'h0004 |=> // R15
    edge_window_pixels == 12'h010) else $error("window size wrong");
  dist_enable_write_a: assert property (reg_wr && reg_addr == 16'h01e0 |=> // R6
    en_dist_median == $past(reg_wdata[0]) && en_temperature == $past(reg_wdata[11])) else $error("enable lost");
endmodule

// file: verification/depth_camera_proc_config_regs_tb.sv
// self-checking bench for the camera configuration register bank
// assumes the rtl package, interface and modules are compiled first
`timescale 1ns/1ps
module depth_camera_proc_config_regs_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0, reg_rd = 1'b0, update_status_load = 1'b0, capture_start = 1'b0;
  logic pixel_valid_in = 1'b0, pixel_plausible_in = 1'b1;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, exposure_duration = 16'h1111;
  logic [15:0] illumination_mod_frequency = 16'h2222, pixel_distance_in = 16'h0000;
  logic [7:0] update_status_in = 8'h00;
  logic [2:0] active_freq_index = 3'h6;
  logic [15:0] reg_rdata, active_exposure, active_mod_frequency, pixel_distance_out;
  logic reg_rvalid, capture_active, sequence_index, pixel_valid_out;
  logic en_dist_median, en_dist_average, en_dist_bilateral, en_dist_sliding;
  logic en_wiggling, en_phase_noise, en_frame_average, en_temperature;
  logic [7:0] median_iter_count, average_kernel_sel, average_iter_count, slide_window_size, frame_avg_count;
  logic [5:0] edge_range_width, edge_spatial_width;
  logic [3:0] edge_iter_count, amp_filter_enables;
  logic [11:0] edge_window_pixels;
  int fails = 0;
  int checked = 0;
  logic [15:0] addrs [12] = '{16'h0120, 16'h0121, 16'h0128, 16'h01d1, 16'h01e0, 16'h01e1, 16'h01e2, 16'h01e4,
    16'h01e5, 16'h01e6, 16'h01e7, 16'h01e9};
  logic [15:0] rsts [12] = '{16'h0001, 16'h05dc, 16'h07d0, 16'h0000, 16'h28c0, 16'h0001, 16'h0100, 16'h13de,
    16'h0005, 16'h0003, 16'h0002, 16'h0000};
  logic [15:0] masks [12] = '{16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'h6cdb, 16'h00ff, 16'hffff, 16'hffff,
    16'h00ff, 16'h003f, 16'h00ff, 16'h000f};
  logic [7:0] codes [13] = '{8'h00, 8'h03, 8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h15, 8'hff};

  depth_camera_proc_config_regs DUT
  (
    .ref_clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .update_status_in,
    .update_status_load, .exposure_duration, .illumination_mod_frequency, .capture_start, .capture_active,
    .sequence_index, .active_exposure, .active_mod_frequency, .active_freq_index, .pixel_distance_in,
    .pixel_valid_in, .pixel_plausible_in, .pixel_distance_out, .pixel_valid_out, .en_dist_median,
    .en_dist_average, .en_dist_bilateral, .en_dist_sliding, .en_wiggling, .en_phase_noise, .en_frame_average,
    .en_temperature, .median_iter_count, .average_kernel_sel, .average_iter_count, .edge_range_width,
    .edge_spatial_width, .edge_iter_count, .slide_window_size, .edge_window_pixels, .frame_avg_count,
    .amp_filter_enables
  );

  // ==========================================================
  // access tasks
  always #4 ref_clk = ~ref_clk;
  task automatic step;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    step;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    step;
    reg_wr = 1'b0;
  endtask
  // answer lands one cycle after the strobe edge
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    step;
    reg_rd = 1'b1;
    reg_addr = a;
    step;
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, exp);
  endtask
  task automatic px(input logic plaus, input logic [15:0] exp);
    step;
    pixel_distance_in = 16'h1000;
    pixel_valid_in = 1'b1;
    pixel_plausible_in = plaus;
    step;
    pixel_valid_in = 1'b0;
    chk({15'h0000, pixel_valid_out}, 16'h0001);
    chk(pixel_distance_out, exp);
  endtask
  task automatic results;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================
  // watchdog, under two hundred cycles of tests expected
  initial
  begin
    #40000;
    fails++;
    results;
  end

  // ==========================================================
  // test sequence
  initial
  begin
    repeat (3) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++)
      rd(addrs[i], rsts[i]);
    for (int i = 0; i < 12; i++)
    begin
      wr(addrs[i], 16'hffff);
      rd(addrs[i], masks[i]);
    end
    wr(16'h01e3, 16'hffff);
    rd(16'h01e3, 16'h0000);
    chk({8'h00, en_dist_median, en_dist_average, en_dist_bilateral, en_dist_sliding, en_wiggling, en_phase_noise,
      en_frame_average, en_temperature}, 16'h00ff);
    chk({median_iter_count, frame_avg_count}, 16'hffff);
    chk({8'h00, slide_window_size}, 16'h00ff);
    chk({average_iter_count, 4'h0, amp_filter_enables}, 16'hff0f);
    wr(16'h01e4, 16'h5a4b);
    chk({edge_iter_count, edge_spatial_width, edge_range_width}, 16'h5a4b);
    wr(16'h01e6, 16'h003f);
    chk({4'h0, edge_window_pixels}, 16'h0f81);
    wr(16'h01e6, 16'h0004);
    chk({4'h0, edge_window_pixels}, 16'h0010);
    for (int k = 0; k < 3; k++)
    begin
      wr(16'h01e2, {8'h07, 8'(k)});
      chk({average_iter_count, average_kernel_sel}, {8'h07, 8'(k)});
    end
    for (int i = 0; i < 13; i++)
    begin
      step;
      update_status_in = codes[i];
      update_status_load = 1'b1;
      step;
      update_status_load = 1'b0;
      rd(16'h01d1, {8'h00, codes[i]});
    end
    wr(16'h0120, 16'h0002);
    wr(16'h0121, 16'h1234);
    wr(16'h0128, 16'h0abc);
    step;
    capture_start = 1'b1;
    step;
    capture_start = 1'b0;
    chk({14'h0000, capture_active, sequence_index}, 16'h0002);
    chk(active_exposure ^ active_mod_frequency, 16'h3333);
    step;
    chk({14'h0000, capture_active, sequence_index}, 16'h0003);
    chk(active_exposure ^ active_mod_frequency, 16'h1888);
    step;
    chk({15'h0000, capture_active}, 16'h0000);
    for (int i = 0; i < 7; i++)
      wr(16'h00c1 + 16'(i), 16'h0100 + 16'(i));
    rd(16'h00c7, 16'h0106);
    wr(16'h01e0, 16'h6000);
    px(1'b1, 16'h1106);
    px(1'b0, 16'h0001);
    wr(16'h01e0, 16'h0000);
    px(1'b0, 16'h1000);
    results;
  end
endmodule
